//--- verilog/objpage_pkg.sv
package objpage_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PAGE = 8'hB1;
	localparam logic [7:0] ADDR_STATUS = 8'hB2;
	localparam logic [7:0] ADDR_CONTROL = 8'hB3;
	// Data byte window, not part of the three documented registers
	localparam logic [7:0] ADDR_DATA = 8'hFA;

	// ------------------------------------------------------------
	// Field positions and sizes
	// ------------------------------------------------------------
	localparam int NUM_OBJECTS = 4;
	localparam int DATA_BYTES = 8;
	localparam int OBJ_W = 2;
	localparam int IDX_W = 3;
	localparam int DLC_W = 4;
	localparam logic [3:0] DLC_MAX = 4'h8;
	localparam logic [2:0] IDX_LAST = 3'h7;
	localparam logic [2:0] IDX_STEP = 3'h1;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam int STAT_LEN_WARN_BIT = 7;
	localparam int STAT_TX_DONE_BIT = 6;
	localparam int STAT_RX_DONE_BIT = 5;

	typedef enum logic [1:0] {
		ROLE_DISABLE = 2'h0,
		ROLE_TRANSMIT = 2'h1,
		ROLE_RECEIVE = 2'h2,
		ROLE_RX_BUFFER = 2'h3
	} role_t;

	typedef struct packed {
		logic [1:0] rsvd;
		logic [OBJ_W-1:0] object_number_select;
		logic index_autoadvance_n;
		logic [IDX_W-1:0] data_byte_index;
	} page_t;

	typedef struct packed {
		role_t object_role_config;
		logic auto_reply_valid;
		logic ident_extended;
		logic [DLC_W-1:0] length_code;
	} control_t;

	// Register port from the processor
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// Events from the protocol engine, each naming its own object
	typedef struct packed {
		logic rx_frame;
		logic [OBJ_W-1:0] rx_object;
		logic [DLC_W-1:0] rx_length;
		logic rx_data_wr;
		logic [IDX_W-1:0] rx_data_idx;
		logic [7:0] rx_data;
		logic tx_done;
		logic [OBJ_W-1:0] tx_object;
	} engine_evt_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_HOLD = 2'h3
	} rdstate_t;

endpackage

//--- verilog/objpage_data_ram.sv
module objpage_data_ram #(
	parameter int WORDS = 32,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic we_a,
	input wire logic [AW-1:0] addr_a,
	input wire logic [7:0] wdata_a,
	input wire logic [AW-1:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic we_b,
	input wire logic [AW-1:0] addr_b,
	input wire logic [7:0] wdata_b
);

	logic [7:0] mem [WORDS];

	// ------------------------------------------------------------
	// Engine write wins a collision; it carries bus data
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (we_b) begin
			mem[addr_b] <= wdata_b;
		end else if (we_a) begin
			mem[addr_a] <= wdata_a;
		end
		rdata_a <= mem[raddr_a];
	end

endmodule

//--- verilog/objpage_ctrl.sv
module objpage_ctrl (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// Processor register port
	input wire objpage_pkg::sfr_req_t SFR_I,
	output logic [7:0] SFR_RDATA_O,
	output logic SFR_RVALID_O,
	// Protocol engine events
	input wire objpage_pkg::engine_evt_t EVT_I,
	// Per-object configuration toward the engine
	output logic [7:0] ROLE_FLAT_O,
	output logic [3:0] ROLE_WRITTEN_O,
	output logic [3:0] REPLY_VALID_O,
	output logic [3:0] IDENT_EXT_O
);

	localparam int N = objpage_pkg::NUM_OBJECTS;
	localparam int AW = objpage_pkg::OBJ_W + objpage_pkg::IDX_W;

	typedef struct packed {
		objpage_pkg::page_t page;
		objpage_pkg::control_t [N-1:0] ctrl;
		logic [N-1:0][7:0] stat;
		logic [N-1:0] role_written;
		objpage_pkg::rdstate_t rs;
		logic [7:0] rsel;
		logic [7:0] rdata;
		logic rvalid;
	} state_t;

	state_t q, d;
	logic [7:0] ram_rdata;
	logic [AW-1:0] cpu_addr;
	logic cpu_data_wr;
	logic cpu_data_rd;
	logic [AW-1:0] eng_addr;

	// ------------------------------------------------------------
	// Data memory for all objects
	// ------------------------------------------------------------
	assign cpu_addr = {q.page.object_number_select, q.page.data_byte_index};
	assign cpu_data_wr = SFR_I.wr && SFR_I.addr == objpage_pkg::ADDR_DATA;
	assign cpu_data_rd = SFR_I.rd && SFR_I.addr == objpage_pkg::ADDR_DATA;
	assign eng_addr = {EVT_I.rx_object, EVT_I.rx_data_idx};

	objpage_data_ram #(
		.WORDS(N * objpage_pkg::DATA_BYTES),
		.AW(AW)
	) u_ram (
		.clk(REF_CLK_I),
		.we_a(cpu_data_wr),
		.addr_a(cpu_addr),
		.wdata_a(SFR_I.wdata),
		.raddr_a(cpu_addr),
		.rdata_a(ram_rdata),
		.we_b(EVT_I.rx_data_wr),
		.addr_b(eng_addr),
		.wdata_b(EVT_I.rx_data)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [objpage_pkg::OBJ_W-1:0] o;
		o = q.page.object_number_select;
		d = q;
		d.rvalid = 1'b0;
		// Hardware clears no flag by itself
		if (SFR_I.wr) begin
			case (SFR_I.addr)
				objpage_pkg::ADDR_PAGE: begin
					d.page = objpage_pkg::page_t'(SFR_I.wdata);
					d.page.rsvd = 2'h0;
				end
				objpage_pkg::ADDR_CONTROL: begin
					d.ctrl[o] = objpage_pkg::control_t'(SFR_I.wdata);
					d.role_written[o] = 1'b1;
				end
				objpage_pkg::ADDR_STATUS: begin
					d.stat[o] = q.stat[o] & SFR_I.wdata;
				end
				default: begin
				end
			endcase
		end
		// Engine updates after software so a same-cycle set wins
		if (EVT_I.rx_frame) begin
			if (EVT_I.rx_length != q.ctrl[EVT_I.rx_object].length_code) begin
				d.stat[EVT_I.rx_object][objpage_pkg::STAT_LEN_WARN_BIT] = 1'b1;
			end
			d.ctrl[EVT_I.rx_object].length_code = EVT_I.rx_length;
			d.stat[EVT_I.rx_object][objpage_pkg::STAT_RX_DONE_BIT] = 1'b1;
		end
		if (EVT_I.tx_done) begin
			d.stat[EVT_I.tx_object][objpage_pkg::STAT_TX_DONE_BIT] = 1'b1;
		end
		// Any data access steps the index unless index_autoadvance_n is set or a page write lands
		if ((cpu_data_wr || cpu_data_rd) && !q.page.index_autoadvance_n
				&& !(SFR_I.wr && SFR_I.addr == objpage_pkg::ADDR_PAGE)) begin
			d.page.data_byte_index = q.page.data_byte_index + objpage_pkg::IDX_STEP;
		end
		// Read path: capture, then wait one cycle for the memory register
		case (q.rs)
			objpage_pkg::ST_IDLE: begin
				if (SFR_I.rd) begin
					d.rsel = SFR_I.addr;
					case (SFR_I.addr)
						objpage_pkg::ADDR_PAGE: d.rdata = q.page;
						objpage_pkg::ADDR_STATUS: d.rdata = q.stat[o];
						objpage_pkg::ADDR_CONTROL: d.rdata = q.ctrl[o];
						default: d.rdata = objpage_pkg::DATA_RST;
					endcase
					d.rs = objpage_pkg::ST_READ;
				end
			end
			objpage_pkg::ST_READ: begin
				if (q.rsel == objpage_pkg::ADDR_DATA) begin
					d.rdata = ram_rdata;
				end
				d.rvalid = 1'b1;
				d.rs = objpage_pkg::ST_HOLD;
			end
			objpage_pkg::ST_HOLD: begin
				d.rs = objpage_pkg::ST_IDLE;
			end
			default: begin
				d.rs = objpage_pkg::ST_IDLE;
			end
		endcase
		if (!RST_N_I) begin
			d = '0;
			d.page = objpage_pkg::PAGE_RST;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		q <= d;
	end

	// ------------------------------------------------------------
	// Outputs, one generate loop with one iteration per object
	// ------------------------------------------------------------
	assign SFR_RDATA_O = q.rdata;
	assign SFR_RVALID_O = q.rvalid;
	assign ROLE_WRITTEN_O = q.role_written;

	for (genvar i = 0; i < N; i++) begin : g_obj
		assign ROLE_FLAT_O[2*i +: 2] = q.ctrl[i].object_role_config;
		assign REPLY_VALID_O[i] = q.ctrl[i].auto_reply_valid;
		assign IDENT_EXT_O[i] = q.ctrl[i].ident_extended;
	end

endmodule

//--- tb/objpage_engine_model.sv
module objpage_engine_model (
	// Requests from the bench
	input wire logic rx_go_i,
	input wire logic tx_go_i,
	input wire logic [1:0] obj_i,
	input wire logic [3:0] len_i,
	// Events toward the block
	output objpage_pkg::engine_evt_t evt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle object and length fields inverted so a stale value never looks valid
	always_comb begin
		evt_o = '0;
		evt_o.rx_frame = rx_go_i;
		evt_o.rx_object = rx_go_i ? obj_i : ~obj_i;
		evt_o.rx_length = rx_go_i ? len_i : ~len_i;
		evt_o.tx_done = tx_go_i;
		evt_o.tx_object = tx_go_i ? obj_i : ~obj_i;
	end
endmodule

//--- tb/objpage_ctrl_asserts.sv
module objpage_ctrl_asserts (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// Register port
	input wire objpage_pkg::sfr_req_t SFR_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic SFR_RVALID_O,
	// Engine and object outputs
	input wire objpage_pkg::engine_evt_t EVT_I,
	input wire logic [7:0] ROLE_FLAT_O,
	input wire logic [3:0] ROLE_WRITTEN_O,
	input wire logic [3:0] REPLY_VALID_O,
	input wire logic [3:0] IDENT_EXT_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic ctl_wr;
	assign ctl_wr = SFR_I.wr && SFR_I.addr == objpage_pkg::ADDR_CONTROL;
	sequence lone_read;
		!SFR_I.rd ##1 !SFR_I.rd ##1 SFR_I.rd;
	endsequence
	sequence one_pulse;
		SFR_RVALID_O ##1 !SFR_RVALID_O;
	endsequence
	chk_read_answer: assert property (lone_read |-> ##2 SFR_RVALID_O)
		else $error("read not answered");
	chk_rvalid_pulse: assert property (SFR_RVALID_O |-> one_pulse)
		else $error("rvalid too long");
	chk_rvalid_cause: assert property (SFR_RVALID_O |-> $past(SFR_I.rd, 2))
		else $error("rvalid without read");
	// Past reset gate: the first edge after reset still sees old outputs
	chk_role_cause: assert property ($past(RST_N_I) && $changed(ROLE_FLAT_O) |-> $past(ctl_wr))
		else $error("role changed without write");
	chk_reply_cause: assert property ($past(RST_N_I) && $changed(REPLY_VALID_O) |-> $past(ctl_wr))
		else $error("reply bit changed without write");
	chk_ext_cause: assert property ($past(RST_N_I) && $changed(IDENT_EXT_O) |-> $past(ctl_wr))
		else $error("format bit changed without write");
	chk_written_sticky: assert property ($past(RST_N_I) |-> (ROLE_WRITTEN_O & $past(ROLE_WRITTEN_O)) ==
		$past(ROLE_WRITTEN_O)) else $error("written flag dropped");
	chk_reset_clears: assert property (disable iff (1'b0) !RST_N_I |=> ROLE_FLAT_O == 8'h00 && !SFR_RVALID_O)
		else $error("outputs not cleared by reset");
endmodule
bind objpage_ctrl objpage_ctrl_asserts chk (.REF_CLK_I, .RST_N_I, .SFR_I, .SFR_RDATA_O, .SFR_RVALID_O, .EVT_I,
	.ROLE_FLAT_O, .ROLE_WRITTEN_O, .REPLY_VALID_O, .IDENT_EXT_O);

//--- tb/can_message_object_page_control_tb_top.sv
module can_message_object_page_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PG = objpage_pkg::ADDR_PAGE;
	localparam logic [7:0] CT = objpage_pkg::ADDR_CONTROL;
	localparam logic [7:0] ST = objpage_pkg::ADDR_STATUS;
	localparam logic [7:0] DT = objpage_pkg::ADDR_DATA;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	objpage_pkg::sfr_req_t req = '0;
	objpage_pkg::engine_evt_t evt;
	logic rx_go = 1'b0;
	logic tx_go = 1'b0;
	logic [3:0] len = 4'h0;
	logic [1:0] obj = 2'h0;
	logic [7:0] rdata, role;
	logic rvalid;
	logic [3:0] wrt, rpl, ext;
	logic [7:0] q[$];
	logic [7:0] r[3];
	logic [31:0] seed = 32'h35;
	int mismatches = 0;
	int n_checks = 0;
	always #12.5 clk = ~clk;
	objpage_ctrl uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .SFR_I(req), .SFR_RDATA_O(rdata), .SFR_RVALID_O(rvalid),
		.EVT_I(evt), .ROLE_FLAT_O(role), .ROLE_WRITTEN_O(wrt), .REPLY_VALID_O(rpl), .IDENT_EXT_O(ext));
	objpage_engine_model eng (.rx_go_i(rx_go), .tx_go_i(tx_go), .obj_i(obj), .len_i(len), .evt_o(evt));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '0;
		@(negedge clk);
	endtask
	// Reads spaced three cycles, as the port demands
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req = '0;
		repeat (2) @(negedge clk);
	endtask
	task automatic ev(input logic rx, input logic [1:0] ob, input logic [3:0] l);
		rx_go = rx;
		tx_go = !rx;
		obj = ob;
		len = l;
		@(negedge clk);
		rx_go = 1'b0;
		tx_go = 1'b0;
		@(negedge clk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(negedge clk) if (rvalid === 1'b1) cmp(rdata, q.pop_front());
	initial begin
		repeat (2000) @(posedge clk);
		mismatches++;
		report_and_stop;
	end
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		rd(PG, objpage_pkg::PAGE_RST);
		rd(8'h00, 8'h00);
		for (int o = 0; o < 4; o++) begin
			wr(PG, {2'h0, o[1:0], 4'h8});
			wr(CT, {o[1:0], o[0], o[1], 4'h8});
		end
		for (int o = 0; o < 4; o++) begin
			wr(PG, {2'h0, o[1:0], 4'h8});
			rd(CT, {o[1:0], o[0], o[1], 4'h8});
		end
		cmp(role, 8'hE4);
		cmp({rpl, ext}, 8'hAC);
		cmp({4'h0, wrt}, 8'h0F);
		// Bench never touches bit timing, so global enable is moot
		wr(PG, 8'h26);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			r[i] = seed[7:0];
			wr(DT, r[i]);
		end
		wr(PG, 8'h26);
		for (int i = 0; i < 3; i++) rd(DT, r[i]);
		rd(PG, 8'h21);
		wr(PG, 8'h2F);
		repeat (2) rd(DT, r[1]);
		wr(PG, 8'h08);
		ev(1'b1, 2'h0, 4'h8);
		rd(ST, 8'h20);
		ev(1'b1, 2'h0, 4'h3);
		ev(1'b1, 2'h0, 4'h3);
		rd(CT, 8'h03);
		rd(ST, 8'hA0);
		wr(ST, 8'h00);
		ev(1'b0, 2'h1, 4'h0);
		wr(PG, 8'h18);
		rd(ST, 8'h40);
		wr(PG, 8'h08);
		rd(ST, 8'h00);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		cmp({4'h0, wrt}, 8'h00);
		rd(PG, objpage_pkg::PAGE_RST);
		report_and_stop;
	end
endmodule
